// file: core/rsic_map.svh
`ifndef RSIC_MAP_SVH
`define RSIC_MAP_SVH

////////////////////////////////////////////////////////////////////////
// Index of each held register in the state array
`define RSIC_NREG      5'h11
`define RSIC_IDX_PCL   5'h00
`define RSIC_IDX_SP    5'h01
`define RSIC_IDX_INTC0 5'h02
`define RSIC_IDX_INTC1 5'h03
`define RSIC_IDX_INTC2 5'h04
`define RSIC_IDX_PA    5'h05
`define RSIC_IDX_PAC   5'h06
`define RSIC_IDX_PB    5'h07
`define RSIC_IDX_PBC   5'h08
`define RSIC_IDX_PC    5'h09
`define RSIC_IDX_PCC   5'h0a
`define RSIC_IDX_WDTC  5'h0b
`define RSIC_IDX_TBC   5'h0c
`define RSIC_IDX_CTRL  5'h0d
`define RSIC_IDX_TM0C0 5'h0e
`define RSIC_IDX_TM1C0 5'h0f
`define RSIC_IDX_TM2C0 5'h10

////////////////////////////////////////////////////////////////////////
// Initial values: load mask in [15:8], value in [7:0]
`define RSIC_INIT_PCL      16'hff00
`define RSIC_INIT_SP       16'hff00
`define RSIC_INIT_INTC0    16'h7f00
`define RSIC_INIT_INTC1    16'hff00
`define RSIC_INIT_INTC2    16'h0f00
`define RSIC_INIT_PA       16'hffff
`define RSIC_INIT_PAC      16'hffff
`define RSIC_INIT_PB       16'h7f7f
`define RSIC_INIT_PBC      16'h7f7f
`define RSIC_INIT_PC       16'h0707
`define RSIC_INIT_PCC      16'h0707
`define RSIC_INIT_WDTC     16'hff53
`define RSIC_INIT_TBC      16'hff37
`define RSIC_INIT_CTRL_POR 16'h8300
`define RSIC_INIT_CTRL     16'h8700
`define RSIC_INIT_TMC0     16'hf800

`endif

// file: core/rsic_pkg.sv
`default_nettype none
`include "rsic_map.svh"

package rsic_pkg;

  // Reset category, lower code is the more complete one
  typedef enum logic [1:0] {
    RSIC_CAT_POR = 2'h0,
    RSIC_CAT_LVR = 2'h1,
    RSIC_CAT_WDN = 2'h2,
    RSIC_CAT_WDH = 2'h3
  } rsic_cat_t;

  // Sequencer states, Gray along run, hold, release
  typedef enum logic [1:0] {
    RSIC_ST_RUN  = 2'h0,
    RSIC_ST_HOLD = 2'h1,
    RSIC_ST_REL  = 2'h3
  } rsic_state_t;

  // Control towards core and watchdog
  typedef struct packed {
    logic      hold;
    logic      wdt_clear;
    logic      wdt_restart;
    rsic_cat_t cat;
  } rsic_ctl_t;

  // Status register reset flags
  typedef struct packed {
    logic timeout_flag;
    logic powerdown_flag;
  } rsic_flags_t;

  // Core write into a held register
  typedef struct packed {
    logic       en;
    logic [4:0] sel;
    logic [7:0] data;
  } rsic_wr_t;

  // Port direction bits, one means input
  typedef struct packed {
    logic [7:0] pa_dir;
    logic [6:0] pb_dir;
    logic [2:0] pc_dir;
  } rsic_dir_t;

endpackage

`default_nettype wire

// file: core/rsic_core.sv
`default_nettype none
`include "rsic_map.svh"

module rsic_core (
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire logic              low_voltage_reset,
  input  wire logic              watchdog_timeout,
  input  wire logic              halt_mode,
  input  wire logic              halt_enter,
  input  wire logic              wdt_soft_clear,
  input  wire rsic_pkg::rsic_wr_t reg_wr,
  input  wire logic [4:0]        rd_sel,
  output logic [7:0]             rd_data_q,
  output rsic_pkg::rsic_flags_t  flags_q,
  output rsic_pkg::rsic_ctl_t    ctl,
  output rsic_pkg::rsic_dir_t    dir
);

  ////////////////////////////////////////////////////////////////////
  // Initial value of one register for one category
  function automatic logic [15:0] init_word(
    input rsic_pkg::rsic_cat_t c,
    input logic [4:0]          idx
  );
    logic [15:0] w;
    w = 16'h0000;
    // Halted watchdog: only PC and SP are touched
    if (c == rsic_pkg::RSIC_CAT_WDH) begin
      if (idx == `RSIC_IDX_PCL) begin
        w = `RSIC_INIT_PCL;
      end else if (idx == `RSIC_IDX_SP) begin
        w = `RSIC_INIT_SP;
      end
    end else begin
      case (idx)
        `RSIC_IDX_PCL:   w = `RSIC_INIT_PCL;
        `RSIC_IDX_SP:    w = `RSIC_INIT_SP;
        `RSIC_IDX_INTC0: w = `RSIC_INIT_INTC0;
        `RSIC_IDX_INTC1: w = `RSIC_INIT_INTC1;
        `RSIC_IDX_INTC2: w = `RSIC_INIT_INTC2;
        `RSIC_IDX_PA:    w = `RSIC_INIT_PA;
        `RSIC_IDX_PAC:   w = `RSIC_INIT_PAC;
        `RSIC_IDX_PB:    w = `RSIC_INIT_PB;
        `RSIC_IDX_PBC:   w = `RSIC_INIT_PBC;
        `RSIC_IDX_PC:    w = `RSIC_INIT_PC;
        `RSIC_IDX_PCC:   w = `RSIC_INIT_PCC;
        `RSIC_IDX_WDTC:  w = `RSIC_INIT_WDTC;
        `RSIC_IDX_TBC:   w = `RSIC_INIT_TBC;
        // Flag bit of control is unknown after power-on
        `RSIC_IDX_CTRL:  w = (c == rsic_pkg::RSIC_CAT_POR) ?
                             `RSIC_INIT_CTRL_POR : `RSIC_INIT_CTRL;
        `RSIC_IDX_TM0C0: w = `RSIC_INIT_TMC0;
        `RSIC_IDX_TM1C0: w = `RSIC_INIT_TMC0;
        `RSIC_IDX_TM2C0: w = `RSIC_INIT_TMC0;
        // Codes past the array are illegal
        default:         w = 16'h0000;
      endcase
    end
    return w;
  endfunction

  // Power-on value with unknown bits taken as zero
  function automatic logic [7:0] por_word(input logic [4:0] idx);
    logic [15:0] w;
    w = init_word(rsic_pkg::RSIC_CAT_POR, idx);
    return w[15:8] & w[7:0];
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Declarations
  logic                  lvr_meta_q;   // Low-voltage sync, first stage
  logic                  lvr_s_q;      // Low-voltage sync, second stage
  logic                  wdt_meta_q;   // Watchdog sync, first stage
  logic                  wdt_s_q;      // Watchdog sync, second stage
  rsic_pkg::rsic_state_t st_q;         // Sequencer state
  rsic_pkg::rsic_state_t st_d;         // Next sequencer state
  rsic_pkg::rsic_cat_t   cat_q;        // Category being applied
  rsic_pkg::rsic_cat_t   cat_d;        // Next category
  rsic_pkg::rsic_cat_t   src_cat;      // Category of live sources
  rsic_pkg::rsic_flags_t flags_d;      // Next flags
  logic [7:0]            regs_q [`RSIC_NREG]; // Held registers
  logic [7:0]            regs_d [`RSIC_NREG]; // Next held registers
  wire                   src_any;      // Any reset source active
  wire                   in_hold;      // Loading initial values
  wire                   in_rel;       // Release cycle
  wire                   wr_ok;        // Core write accepted
  wire                   rd_ok;        // Read index in range

  ////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for the detector levels
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lvr_meta_q <= 1'b0;
      lvr_s_q    <= 1'b0;
      wdt_meta_q <= 1'b0;
      wdt_s_q    <= 1'b0;
    end else begin
      lvr_meta_q <= low_voltage_reset;
      lvr_s_q    <= lvr_meta_q;
      wdt_meta_q <= watchdog_timeout;
      wdt_s_q    <= wdt_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Source decode and category choice
  assign src_any = lvr_s_q | wdt_s_q;
  assign in_hold = (st_q == rsic_pkg::RSIC_ST_HOLD);
  assign in_rel  = (st_q == rsic_pkg::RSIC_ST_REL);
  // Low voltage beats watchdog; halt picks the halted kind
  assign src_cat = lvr_s_q   ? rsic_pkg::RSIC_CAT_LVR :
                   halt_mode ? rsic_pkg::RSIC_CAT_WDH :
                               rsic_pkg::RSIC_CAT_WDN;

  // New entry, or upgrade to a more complete category
  always_comb begin
    cat_d = cat_q;
    if (src_any && (st_q != rsic_pkg::RSIC_ST_HOLD)) begin
      cat_d = src_cat;
    end else if (src_any && (src_cat < cat_q)) begin
      cat_d = src_cat;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sequencer: hold while any source stays, then one release cycle
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      rsic_pkg::RSIC_ST_RUN: begin
        if (src_any) begin
          st_d = rsic_pkg::RSIC_ST_HOLD;
        end
      end
      rsic_pkg::RSIC_ST_HOLD: begin
        if (!src_any) begin
          st_d = rsic_pkg::RSIC_ST_REL;
        end
      end
      rsic_pkg::RSIC_ST_REL: begin
        // A new source during release re-enters hold
        st_d = src_any ? rsic_pkg::RSIC_ST_HOLD : rsic_pkg::RSIC_ST_RUN;
      end
      // Unused code falls back to hold
      default: st_d = rsic_pkg::RSIC_ST_HOLD;
    endcase
  end

  // Power-on starts in hold with the power-on category
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_q  <= rsic_pkg::RSIC_ST_HOLD;
      cat_q <= rsic_pkg::RSIC_CAT_POR;
    end else begin
      st_q  <= st_d;
      cat_q <= cat_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Control outputs, all from flops
  assign ctl.hold        = in_hold;
  assign ctl.wdt_clear   = in_hold;
  assign ctl.wdt_restart = in_rel;
  assign ctl.cat         = cat_q;

  ////////////////////////////////////////////////////////////////////
  // Reset flags: reset load wins over core events
  always_comb begin
    flags_d = flags_q;
    if (in_hold) begin
      unique case (cat_q)
        rsic_pkg::RSIC_CAT_POR: flags_d = 2'h0;
        rsic_pkg::RSIC_CAT_LVR: flags_d = flags_q;
        rsic_pkg::RSIC_CAT_WDN: flags_d.timeout_flag = 1'b1;
        rsic_pkg::RSIC_CAT_WDH: flags_d = 2'h3;
      endcase
    end else if (wdt_soft_clear) begin
      flags_d = 2'h0;
    end else if (halt_enter) begin
      flags_d.timeout_flag   = 1'b0;
      flags_d.powerdown_flag = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      flags_q <= 2'h0;
    end else begin
      flags_q <= flags_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Held registers: masked load while in hold, else core writes
  assign wr_ok = reg_wr.en && !in_hold;

  for (genvar i = 0; i < `RSIC_NREG; i++) begin : g_reg
    wire [15:0] iw = init_word(cat_q, 5'(i)); // Load mask, value
    wire [15:0] lw = init_word(rsic_pkg::RSIC_CAT_LVR, 5'(i));
    wire        hit = wr_ok && (reg_wr.sel == 5'(i));

    // Unknown and unchanged bits keep their content
    assign regs_d[i] = in_hold ? ((regs_q[i] & ~iw[15:8]) | (iw[7:0] & iw[15:8])) :
                       hit     ? (reg_wr.data & lw[15:8]) :
                                 regs_q[i];

    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        regs_q[i] <= por_word(5'(i));
      end else begin
        regs_q[i] <= regs_d[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Registered read port, out-of-range reads as zero
  assign rd_ok = (rd_sel < `RSIC_NREG);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_q <= 8'h00;
    end else begin
      rd_data_q <= rd_ok ? regs_q[rd_sel] : 8'h00;
    end
  end

  // Port directions straight from the control registers
  assign dir.pa_dir = regs_q[`RSIC_IDX_PAC];
  assign dir.pb_dir = regs_q[`RSIC_IDX_PBC][6:0];
  assign dir.pc_dir = regs_q[`RSIC_IDX_PCC][2:0];

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  wire full_rel = in_rel && (cat_q != rsic_pkg::RSIC_CAT_WDH);

  chk_por_flags: assert property (
    (in_hold && cat_q == rsic_pkg::RSIC_CAT_POR) |=> (flags_q == 2'h0))
    else $error("flags not clear after power-on");

  chk_lvr_flags: assert property (
    (in_hold && cat_q == rsic_pkg::RSIC_CAT_LVR) |=> $stable(flags_q))
    else $error("low-voltage reset changed flags");

  chk_wdn_flags: assert property (
    (in_hold && cat_q == rsic_pkg::RSIC_CAT_WDN)
    |=> flags_q.timeout_flag && $stable(flags_q.powerdown_flag))
    else $error("running watchdog flags wrong");

  chk_wdh_flags: assert property (
    (in_hold && cat_q == rsic_pkg::RSIC_CAT_WDH) |=> (flags_q == 2'h3))
    else $error("halted watchdog flags wrong");

  chk_int_off: assert property (
    full_rel |-> (regs_q[`RSIC_IDX_INTC0] == 8'h00) &&
                 (regs_q[`RSIC_IDX_INTC1] == 8'h00) &&
                 (regs_q[`RSIC_IDX_INTC2] == 8'h00))
    else $error("interrupts enabled after reset");

  chk_wdt_restart: assert property (
    (in_hold && !src_any) |=> ctl.wdt_restart && !ctl.wdt_clear ##1 !ctl.wdt_restart)
    else $error("watchdog restart pulse wrong");

  chk_tmr_off: assert property (
    full_rel |-> ((regs_q[`RSIC_IDX_TM0C0] | regs_q[`RSIC_IDX_TM1C0] |
                   regs_q[`RSIC_IDX_TM2C0]) == 8'h00))
    else $error("timer left on after reset");

  chk_dir_input: assert property (
    full_rel |-> (dir == 18'h3ffff))
    else $error("port not input after reset");

  chk_pc_sp_zero: assert property (
    in_rel |-> (regs_q[`RSIC_IDX_PCL] == 8'h00) && (regs_q[`RSIC_IDX_SP] == 8'h00))
    else $error("program counter or stack pointer not reset");

  chk_halt_keep: assert property (
    (in_hold && cat_q == rsic_pkg::RSIC_CAT_WDH && $past(in_hold))
    |-> $stable(regs_q[`RSIC_IDX_PAC]) && $stable(regs_q[`RSIC_IDX_WDTC]))
    else $error("halted watchdog changed a register");

  chk_ctrl_load: assert property (
    (in_hold && cat_q == rsic_pkg::RSIC_CAT_LVR) |=> (regs_q[`RSIC_IDX_CTRL] == 8'h00))
    else $error("control not loaded on low voltage");

  chk_cat_prio: assert property (
    (in_hold && lvr_s_q) |=> (cat_q inside {rsic_pkg::RSIC_CAT_POR, rsic_pkg::RSIC_CAT_LVR}))
    else $error("low voltage did not take precedence");

  cov_lvr_reset: cover property (
    in_hold && cat_q == rsic_pkg::RSIC_CAT_LVR ##1 in_rel);
  cov_wdh_reset: cover property (
    in_hold && cat_q == rsic_pkg::RSIC_CAT_WDH ##1 in_rel);
  cov_upgrade: cover property (
    in_hold && cat_q == rsic_pkg::RSIC_CAT_WDN ##1 cat_q == rsic_pkg::RSIC_CAT_LVR);

endmodule

`default_nettype wire

// file: bench/rsic_wdt_model.sv
`default_nettype none
`include "rsic_map.svh"

module rsic_wdt_model (
  input  wire logic                mclk,
  input  wire logic                reset_n,
  input  wire rsic_pkg::rsic_ctl_t ctl,
  output var  logic [7:0]          wdt_count_q
);
  timeunit 1ns;
  timeprecision 1ps;

  logic run_q; // Counting enabled

  ////////////////////////////////////////////////////////////////////////
  // Watchdog count: cleared while held, counts again from restart
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wdt_count_q <= 8'h00;
      run_q       <= 1'b0;
    end else if (ctl.wdt_clear) begin
      wdt_count_q <= 8'h00;
      run_q       <= 1'b0;
    end else if (ctl.wdt_restart || run_q) begin
      wdt_count_q <= wdt_count_q + 8'h01;
      run_q       <= 1'b1;
    end
  end
endmodule

`default_nettype wire

// file: bench/rsic_core_tb_top.sv
`default_nettype none
`include "rsic_map.svh"

module rsic_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  mclk, reset_n, low_voltage_reset, watchdog_timeout;
  logic                  halt_mode, halt_enter, wdt_soft_clear;
  rsic_pkg::rsic_wr_t    reg_wr;
  logic [4:0]            rd_sel;
  logic [7:0]            rd_data_q, wdt_count_q;
  rsic_pkg::rsic_flags_t flags_q;
  rsic_pkg::rsic_ctl_t   ctl;
  rsic_pkg::rsic_dir_t   dir;
  int                    err_total, num_checks;
  logic [7:0]            shadow [17]; // Expected register contents
  logic [1:0]            fl;          // Expected flags

  // Load mask and value per register, non power-on categories
  localparam logic [15:0] INIT_TAB [17] = '{`RSIC_INIT_PCL, `RSIC_INIT_SP, `RSIC_INIT_INTC0,
    `RSIC_INIT_INTC1, `RSIC_INIT_INTC2, `RSIC_INIT_PA, `RSIC_INIT_PAC, `RSIC_INIT_PB, `RSIC_INIT_PBC,
    `RSIC_INIT_PC, `RSIC_INIT_PCC, `RSIC_INIT_WDTC, `RSIC_INIT_TBC, `RSIC_INIT_CTRL,
    `RSIC_INIT_TMC0, `RSIC_INIT_TMC0, `RSIC_INIT_TMC0};

  rsic_core i_dut (.mclk(mclk), .reset_n(reset_n), .low_voltage_reset(low_voltage_reset),
    .watchdog_timeout(watchdog_timeout), .halt_mode(halt_mode), .halt_enter(halt_enter),
    .wdt_soft_clear(wdt_soft_clear), .reg_wr(reg_wr), .rd_sel(rd_sel), .rd_data_q(rd_data_q),
    .flags_q(flags_q), .ctl(ctl), .dir(dir));

  rsic_wdt_model i_wdt (.mclk(mclk), .reset_n(reset_n), .ctl(ctl), .wdt_count_q(wdt_count_q));

  ////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Bounded wait for hold at a level
  task automatic wait_hold(input logic lvl);
    int n;
    n = 0;
    while (ctl.hold !== lvl) begin
      @(posedge mclk);
      #1;
      n++;
      if (n > 12) begin
        err_total++;
        print_verdict();
      end
    end
  endtask

  task automatic wr(input logic [4:0] s, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= '{en: 1'b1, sel: s, data: d};
    @(posedge mclk);
    reg_wr.en <= 1'b0;
  endtask

  // Fill every register with a pattern, unimplemented bits read 0
  task automatic wr_all();
    for (int i = 0; i < 17; i++) begin
      wr(5'(i), 8'ha5 ^ 8'(i));
      shadow[i] = (8'ha5 ^ 8'(i)) & INIT_TAB[i][15:8];
    end
  endtask

  // One-cycle flag event: halt or soft clear
  task automatic evt(input logic h);
    @(posedge mclk);
    halt_enter     <= h;
    wdt_soft_clear <= !h;
    @(posedge mclk);
    halt_enter     <= 1'b0;
    wdt_soft_clear <= 1'b0;
  endtask

  // Expected contents after a load of category c
  task automatic reload(input rsic_pkg::rsic_cat_t c);
    logic [15:0] m;
    for (int i = 0; i < 17; i++) begin
      m = INIT_TAB[i];
      if (c == rsic_pkg::RSIC_CAT_POR) begin
        shadow[i] = (i == `RSIC_IDX_CTRL) ? 8'(`RSIC_INIT_CTRL_POR) : m[7:0];
      end else if (c != rsic_pkg::RSIC_CAT_WDH) begin
        shadow[i] = (shadow[i] & ~m[15:8]) | m[7:0];
      end else if (i < 2) begin
        shadow[i] = 8'h00;
      end
    end
  endtask

  task automatic pon();
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    #1;
    reload(rsic_pkg::RSIC_CAT_POR);
    fl = 2'h0;
  endtask

  // Raise a reset source, try a write in hold, release and check restart
  task automatic src(input logic lv, input logic wd, input logic hm, input rsic_pkg::rsic_cat_t c);
    @(posedge mclk);
    halt_mode         <= hm;
    low_voltage_reset <= lv;
    watchdog_timeout  <= wd;
    wait_hold(1'b1);
    chk("category", ctl.cat, c);
    wr(`RSIC_IDX_PAC, 8'h3c);
    // Core stays halted after the reset is released; the next call sets the mode again
    low_voltage_reset <= 1'b0;
    watchdog_timeout  <= 1'b0;
    wait_hold(1'b0);
    chk("restart", ctl.wdt_restart, 1'b1);
    chk("wdt count", wdt_count_q, 8'h00);
    @(posedge mclk);
    #1;
    chk("restart", ctl.wdt_restart, 1'b0);
    repeat (3) @(posedge mclk);
    #1;
    chk("wdt running", wdt_count_q != 8'h00, 1'b1);
    reload(c);
  endtask

  // Read back all registers, one unmapped, ports and flags
  task automatic verify(input string nm);
    logic [7:0] v;
    for (int i = 0; i < 18; i++) begin
      @(posedge mclk);
      rd_sel <= 5'(i);
      @(posedge mclk);
      #1;
      v = rd_data_q;
      chk($sformatf("reg %0d", i), v, (i < 17) ? shadow[i] : 8'h00);
    end
    chk("dir", dir, {shadow[`RSIC_IDX_PAC], shadow[`RSIC_IDX_PBC][6:0], shadow[`RSIC_IDX_PCC][2:0]});
    chk("flags", flags_q, fl);
    $display("test %s done", nm);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  initial begin
    reset_n           = 1'b0;
    low_voltage_reset = 1'b0;
    watchdog_timeout  = 1'b0;
    halt_mode         = 1'b0;
    halt_enter        = 1'b0;
    wdt_soft_clear    = 1'b0;
    reg_wr            = '0;
    rd_sel            = 5'h00;
    err_total         = 0;
    num_checks        = 0;
    pon();
    verify("power_on");
    wr_all();
    evt(1'b1);
    src(1'b1, 1'b0, 1'b0, rsic_pkg::RSIC_CAT_LVR);
    fl = 2'h1;
    verify("low_voltage");
    wr_all();
    evt(1'b0);
    src(1'b0, 1'b1, 1'b0, rsic_pkg::RSIC_CAT_WDN);
    fl = 2'h2;
    verify("watchdog_run");
    wr_all();
    src(1'b0, 1'b1, 1'b1, rsic_pkg::RSIC_CAT_WDH);
    fl = 2'h3;
    verify("watchdog_halt");
    wr_all();
    evt(1'b0);
    src(1'b1, 1'b1, 1'b0, rsic_pkg::RSIC_CAT_LVR);
    fl = 2'h0;
    verify("priority");
    wr_all();
    evt(1'b1);
    pon();
    verify("power_on_again");
    print_verdict();
  end
endmodule

`default_nettype wire
